// [tb/rcs_top_asserts.sv]
`timescale 1ns/1ps
`include "rcs_defs.svh"
module rcs_top_asserts #(
  parameter int ADDR_W = `RCS_ADDR_W
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic porCause,
  input wire logic brownCause,
  input wire logic pinCause,
  input wire logic wdogCause,
  input wire logic brownoutDetectEnable,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic powerOnFlag,
  input wire logic brownoutEventFlag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire logic atCause = paddr == {`RCS_IDX_CAUSE, 2'b00};
  wire logic rdCause = pready && !pwrite && atCause;
  wire logic cWr = psel && penable && pready && pwrite && atCause;
  wire logic okWr = cWr && !pslverr && pstrb[0];
  sequence s_setup; psel && !penable; endsequence
  sequence s_causeWr; okWr; endsequence
  property p_rdy; s_setup |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_rdyOne; pready |=> !pready; endproperty
  a_rdyOne: assert property (p_rdyOne) else $error("ready too long");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error reply");
  property p_upper; rdCause |-> prdata[31:2] == 30'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper bits set");
  property p_rd; rdCause |-> prdata[1:0] == {powerOnFlag, brownoutEventFlag};
  endproperty
  a_rd: assert property (p_rd) else $error("flag read wrong");
  property p_por; $fell(reset) && $past(porCause) |-> !powerOnFlag; endproperty
  a_por: assert property (p_por) else $error("power flag not clear");
  property p_wr;
    s_causeWr |=> {powerOnFlag, brownoutEventFlag} == $past(pwdata[1:0]);
  endproperty
  a_wr: assert property (p_wr) else $error("flag write lost");
  property p_hold;
    !reset && !okWr |=> $stable({powerOnFlag, brownoutEventFlag});
  endproperty
  a_hold: assert property (p_hold) else $error("flag changed");
endmodule : rcs_top_asserts
bind rcs_top rcs_top_asserts #(.ADDR_W(ADDR_W)) u_rcs_top_asserts (
  .sys_clk, .reset, .porCause, .brownCause, .pinCause, .wdogCause,
  .brownoutDetectEnable, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .pready, .prdata, .pslverr, .irq, .powerOnFlag, .brownoutEventFlag);

// [tb/test_reset_cause_status_register.sv]
`timescale 1ns/1ps
`include "rcs_defs.svh"
module test_reset_cause_status_register;
  import rcs_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic porCause = 1'b1, brownCause = 1'b0, pinCause = 1'b0, wdogCause = 1'b0;
  logic brownoutDetectEnable = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h27c5a9bd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, irq, powerOnFlag, brownoutEventFlag;
  int errCount = 0, checkCount = 0, poM = 0, boM = 0, statM, kindM;
  logic [31:0] bm = 32'hfffffffe;
  localparam logic [11:0] AC = {`RCS_IDX_CAUSE, 2'b00};
  localparam logic [11:0] AS = {`RCS_IDX_ISTAT, 2'b00};
  localparam logic [11:0] AM = {`RCS_IDX_IMASK, 2'b00};
  localparam logic [11:0] AK = {`RCS_IDX_KIND, 2'b00};
  always #10 sys_clk = ~sys_clk;
  rcs_top u_rcs_top (.sys_clk, .reset, .porCause, .brownCause, .pinCause,
    .wdogCause, .brownoutDetectEnable, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .prdata, .pslverr, .irq, .powerOnFlag,
    .brownoutEventFlag);
  ////////////////////////////////////////////////////////////////////////
  task automatic chkVal(input logic [31:0] g, input logic [31:0] e);
    checkCount++;
    if (g !== e) begin
      errCount++;
      $display("[ERR] %0t value %h expected %h", $time, g, e);
    end
  endtask : chkVal
  task automatic chkBit(input logic g, input logic e);
    checkCount++;
    if (g !== e) begin
      errCount++;
      $display("[ERR] %0t bit %b expected %b", $time, g, e);
    end
  endtask : chkBit
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : seed;
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdChk(input logic [11:0] a, input int e,
                       input logic [31:0] m);
    apb(1'b0, a, 32'h0, 4'hf);
    chkVal(rd & m, e & m);
    chkBit(er, 1'b0);
  endtask : rdChk
  task automatic rst(input int k, input logic en);
    @(posedge sys_clk);
    reset <= 1'b1;
    porCause <= k == 1;
    brownCause <= k == 2;
    pinCause <= k == 3;
    wdogCause <= k == 4;
    brownoutDetectEnable <= en;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    if (k == 1) poM = 0;
    if (k == 1) bm = 32'hfffffffe;
    if (k == 2 && en) boM = 0;
    statM = 1 << (k - 1);
    kindM = k;
  endtask : rst
  task automatic endSim;
    $display("checks %0d errors %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : endSim
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3000) @(posedge sys_clk);
    errCount++;
    $display("[ERR] %0t watchdog expired", $time);
    endSim();
  end
  initial begin
    rst(1, 1'b1);
    rdChk(AC, poM * 2 + boM, bm);
    chkBit(powerOnFlag, 1'b0);
    rdChk(AS, statM, '1);
    rdChk(AK, kindM, '1);
    apb(1'b1, AC, seed | 32'h3, 4'hf);
    {poM, boM, bm} = {32'd1, 32'd1, 32'hffffffff};
    rdChk(AC, 3, '1);
    apb(1'b1, AC, 32'h0, 4'he);
    rdChk(AC, 3, '1);
    $display("test flags done");
    for (int k = 2; k < 5; k++) begin
      rst(k, 1'b1);
      rdChk(AC, poM * 2 + boM, '1);
      chkBit(powerOnFlag, poM[0]);
      chkBit(brownoutEventFlag, boM[0]);
      rdChk(AK, kindM, '1);
      rdChk(AS, statM, '1);
    end
    $display("test causes done");
    apb(1'b1, AM, 32'hf, 4'hf);
    @(posedge sys_clk);
    chkBit(irq, 1'b1);
    rdChk(AM, 32'hf, '1);
    apb(1'b1, AS, 32'hf, 4'hf);
    @(posedge sys_clk);
    chkBit(irq, 1'b0);
    $display("test irq done");
    apb(1'b0, 12'hffc, 32'h0, 4'hf);
    chkBit(er, 1'b1);
    chkVal(rd, 32'h0);
    apb(1'b0, AC + 12'h1, 32'h0, 4'hf);
    chkBit(er, 1'b1);
    apb(1'b1, AC, 32'h3, 4'hf);
    rst(2, 1'b0);
    rdChk(AC, 2, 32'hfffffffe);
    $display("test errors done");
    endSim();
  end
endmodule : test_reset_cause_status_register

// [verilog/rcs_apb_slave.sv]
`timescale 1ns/1ps
`include "rcs_defs.svh"

module rcs_apb_slave
  import rcs_pkg::*;
#(
  parameter int ADDR_W = `RCS_ADDR_W
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  rcs_reg_if.bus regs
);

  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic setup;
  logic done;
  logic aligned;

  ////////////////////////////////////////////////////////////////////////
  // Decode
  assign setup = psel && !penable;
  assign done = psel && penable && pready_r;
  assign aligned = (paddr[1:0] == 2'b00);
  assign regs.idx = paddr[ADDR_W-1:2];
  assign regs.wdata = pwdata[7:0];
  // Only lane 0 holds data; bad address or missing lane stores nothing
  assign regs.wrStb = done && pwrite && aligned && regs.hit && pstrb[0];

  ////////////////////////////////////////////////////////////////////////
  // Answer one cycle after setup, no wait states
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pready_r <= 1'b0;
      prdata_r <= `RCS_ZERO_WORD;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      pready_r <= 1'b1;
      pslverr_r <= !(aligned && regs.hit);
      prdata_r <= (aligned && regs.hit && !pwrite) ? regs.rdata
                                                   : `RCS_ZERO_WORD;
    end else if (done) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  assign pready = pready_r;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

endmodule : rcs_apb_slave

// [verilog/rcs_defs.svh]
`ifndef RCS_DEFS_SVH
`define RCS_DEFS_SVH

// Register indices; byte address is four times the index
`define RCS_IDX_CAUSE 10'h08e
`define RCS_IDX_ISTAT 10'h090
`define RCS_IDX_IMASK 10'h091
`define RCS_IDX_KIND 10'h092

// Reset-cause register fields
`define RCS_BIT_BROWN 0
`define RCS_BIT_POR 1
`define RCS_CAUSE_W 2
`define RCS_POR_FLAG_RST 1'b0
`define RCS_BROWN_FLAG_RST 1'b0

// Interrupt status and mask fields
`define RCS_EVT_W 4
`define RCS_EVT_POWER 0
`define RCS_EVT_BROWN 1
`define RCS_EVT_PIN 2
`define RCS_EVT_WDOG 3
`define RCS_ISTAT_RST 4'h0
`define RCS_IMASK_RST 4'h0

// Bus constants
`define RCS_ADDR_W 12
`define RCS_IDX_W 10
`define RCS_KIND_W 3
`define RCS_ZERO_WORD 32'h0000_0000

`endif

// [verilog/rcs_irq_ctrl.sv]
`timescale 1ns/1ps
`include "rcs_defs.svh"

module rcs_irq_ctrl
  import rcs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire rcs_evt_t evt,
  rcs_reg_if.obs regs,
  output rcs_evt_t istat,
  output rcs_evt_t imask,
  output logic irq
);

  rcs_evt_t istat_r;
  rcs_evt_t istat_nxt;
  rcs_evt_t imask_r;
  logic irq_r;
  logic wrStat;
  logic wrMask;

  assign wrStat = regs.wrStb && (regs.idx == `RCS_IDX_ISTAT);
  assign wrMask = regs.wrStb && (regs.idx == `RCS_IDX_IMASK);
  // Set wins over a write-one clear in the same cycle; mask not consulted
  assign istat_nxt = (istat_r & ~(wrStat ? regs.wdata[`RCS_EVT_W-1:0]
                                         : `RCS_ISTAT_RST)) | evt;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      istat_r <= `RCS_ISTAT_RST;
      imask_r <= `RCS_IMASK_RST;
      irq_r <= 1'b0;
    end else begin
      istat_r <= istat_nxt;
      if (wrMask) begin
        imask_r <= regs.wdata[`RCS_EVT_W-1:0];
      end
      irq_r <= |(istat_nxt & (wrMask ? regs.wdata[`RCS_EVT_W-1:0]
                                     : imask_r));
    end
  end

  assign istat = istat_r;
  assign imask = imask_r;
  assign irq = irq_r;

endmodule : rcs_irq_ctrl

// [verilog/rcs_pkg.sv]
`include "rcs_defs.svh"

package rcs_pkg;

  typedef enum logic [`RCS_KIND_W-1:0] {
    RCS_KIND_NONE,
    RCS_KIND_POWER,
    RCS_KIND_BROWN,
    RCS_KIND_PIN,
    RCS_KIND_WDOG
  } rcs_kind_t;

  typedef logic [`RCS_EVT_W-1:0] rcs_evt_t;
  typedef logic [`RCS_IDX_W-1:0] rcs_idx_t;

endpackage : rcs_pkg

// [verilog/rcs_reg_if.sv]
`timescale 1ns/1ps
`include "rcs_defs.svh"

interface rcs_reg_if;
  logic wrStb;
  logic [`RCS_IDX_W-1:0] idx;
  logic [7:0] wdata;
  logic [31:0] rdata;
  logic hit;

  modport bus (output wrStb, output idx, output wdata,
               input rdata, input hit);
  modport core (input wrStb, input idx, input wdata,
                output rdata, output hit);
  modport obs (input wrStb, input idx, input wdata);
endinterface : rcs_reg_if

// [verilog/rcs_top.sv]
// Overview of operation
// - An event flag is set when its event happens, whatever the enables.
// - The kind register tells apart all four kinds of reset; the reset-cause register holds only two flags.
// - After power-on the brown-out flag is zero, like the power-on flag.
// - With brown-out detection off the brown-out flag means nothing.
// - Bits 7 to 2 of the reset-cause register read zero and ignore writes.
// - Bit 1 is the read-write power-on flag, zero after a power-on reset.
// - Bit 0 is the read-write brown-out flag, zero after a brown-out reset with detection on.
`timescale 1ns/1ps
`include "rcs_defs.svh"

module rcs_top
  import rcs_pkg::*;
#(
  parameter int ADDR_W = `RCS_ADDR_W
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic porCause,
  input wire logic brownCause,
  input wire logic pinCause,
  input wire logic wdogCause,
  input wire logic brownoutDetectEnable,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic irq,
  output logic powerOnFlag,
  output logic brownoutEventFlag
);

  rcs_reg_if regs ();

  logic porFlag_r;
  logic brownFlag_r;
  rcs_kind_t kind_r;
  rcs_kind_t kind_nxt;
  logic relDly_r;
  logic relPulse;
  logic wrCause;
  rcs_evt_t evt;
  rcs_evt_t istat;
  rcs_evt_t imask;
  logic [`RCS_CAUSE_W-1:0] causeBits;

  ////////////////////////////////////////////////////////////////////////
  // Bus slave
  rcs_apb_slave #(.ADDR_W(ADDR_W)) u_apb (
    .sys_clk(sys_clk),
    .reset(reset),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .regs(regs.bus)
  );

  ////////////////////////////////////////////////////////////////////////
  // Reset kind, caught while reset is held; power-on has priority
  assign kind_nxt = porCause ? RCS_KIND_POWER :
                    brownCause ? RCS_KIND_BROWN :
                    pinCause ? RCS_KIND_PIN :
                    wdogCause ? RCS_KIND_WDOG : kind_r;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      kind_r <= kind_nxt;
    end
  end

  // High during reset and for the first cycle after release
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      relDly_r <= 1'b1;
    end else begin
      relDly_r <= 1'b0;
    end
  end

  assign relPulse = relDly_r && !reset;

  assign evt[`RCS_EVT_POWER] = relPulse && (kind_r == RCS_KIND_POWER);
  assign evt[`RCS_EVT_BROWN] = relPulse && (kind_r == RCS_KIND_BROWN);
  assign evt[`RCS_EVT_PIN] = relPulse && (kind_r == RCS_KIND_PIN);
  assign evt[`RCS_EVT_WDOG] = relPulse && (kind_r == RCS_KIND_WDOG);

  ////////////////////////////////////////////////////////////////////////
  // Reset-cause flags; kept through pin and watchdog resets
  assign wrCause = regs.wrStb && (regs.idx == `RCS_IDX_CAUSE);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      if (porCause) begin
        porFlag_r <= `RCS_POR_FLAG_RST;
        brownFlag_r <= `RCS_BROWN_FLAG_RST;
      end else if (brownCause && brownoutDetectEnable) begin
        brownFlag_r <= `RCS_BROWN_FLAG_RST;
      end
    end else if (wrCause) begin
      porFlag_r <= regs.wdata[`RCS_BIT_POR];
      brownFlag_r <= regs.wdata[`RCS_BIT_BROWN];
    end
  end

  assign causeBits[`RCS_BIT_POR] = porFlag_r;
  assign causeBits[`RCS_BIT_BROWN] = brownFlag_r;

  ////////////////////////////////////////////////////////////////////////
  // Read decode; unused upper bits read zero
  assign regs.hit = (regs.idx == `RCS_IDX_CAUSE) ||
                    (regs.idx == `RCS_IDX_ISTAT) ||
                    (regs.idx == `RCS_IDX_IMASK) ||
                    (regs.idx == `RCS_IDX_KIND);
  assign regs.rdata =
    (regs.idx == `RCS_IDX_CAUSE) ?
      {{(32-`RCS_CAUSE_W){1'b0}}, causeBits} :
    (regs.idx == `RCS_IDX_ISTAT) ? {{(32-`RCS_EVT_W){1'b0}}, istat} :
    (regs.idx == `RCS_IDX_IMASK) ? {{(32-`RCS_EVT_W){1'b0}}, imask} :
    (regs.idx == `RCS_IDX_KIND) ? {{(32-`RCS_KIND_W){1'b0}}, kind_r} :
    `RCS_ZERO_WORD;

  ////////////////////////////////////////////////////////////////////////
  // Event status and interrupt
  rcs_irq_ctrl u_irq (
    .sys_clk(sys_clk),
    .reset(reset),
    .evt(evt),
    .regs(regs.obs),
    .istat(istat),
    .imask(imask),
    .irq(irq)
  );

  assign powerOnFlag = porFlag_r;
  assign brownoutEventFlag = brownFlag_r;

endmodule : rcs_top
